// ==== rtl/touch_sense_defines.vh ====
// register offsets, field positions and reset values for the touch sense counter block
`ifndef TOUCH_SENSE_DEFINES_VH
`define TOUCH_SENSE_DEFINES_VH
`define ADDR_COUNT_LOW_BYTE   8'ha4
`define ADDR_COUNT_HIGH_BYTE  8'ha5
`define ADDR_EVENT_FLAGS      8'ha6
`define ADDR_TIMER_COUNT      8'ha7
`define ADDR_SLEW_CONTROL     8'ha8
`define BIT_INPUT_EDGE_FLAG   7
`define BIT_LOW_CARRY_FLAG    6
`define BIT_HIGH_CARRY_FLAG   5
`define BIT_MEAS_DONE_FLAG    4
`define RST_BYTE              8'h00
`define RST_TIMER_COUNT       7'h00
`endif

// ==== rtl/sense_counter16.v ====
// sixteen-bit measurement counter split into low and high bytes with carry pulses
`timescale 1ns/1ps
`default_nettype none
module sense_counter16 #(
  parameter WIDTH = 8
) (
  input  wire             clk_sys,
  input  wire             srst,
  input  wire             count_enable,
  input  wire             count_run,
  output reg  [WIDTH-1:0] count_low_byte,
  output reg  [WIDTH-1:0] count_high_byte,
  output reg              low_carry_pulse,
  output reg              high_carry_pulse
);
  wire low_full;
  wire high_full;
  assign low_full  = &count_low_byte;
  assign high_full = &count_high_byte;
  // ==========================================================
  // counting
  always @(posedge clk_sys)
  begin
    if (srst || !count_enable)
    begin
      count_low_byte   <= {WIDTH{1'b0}}; // R3 R13
      count_high_byte  <= {WIDTH{1'b0}}; // R3
      low_carry_pulse  <= 1'b0;
      high_carry_pulse <= 1'b0;
    end
    else if (count_run)
    begin
      count_low_byte   <= count_low_byte + {{(WIDTH-1){1'b0}}, 1'b1};
      low_carry_pulse  <= low_full;
      high_carry_pulse <= low_full & high_full;
      if (low_full)
      begin
        count_high_byte <= count_high_byte + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
    else
    begin
      low_carry_pulse  <= 1'b0;
      high_carry_pulse <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/touch_sense_counter_status.v ====
// register block for the touch sense measurement counter and its event flags
//
// The address-and-strobe port was left to the implementer.
`include "touch_sense_defines.vh"
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1 - high byte register reads current upper counter byte, valid when halted
// R2 - software reads counts only after the stop event halts the counter
// R3 - disabled counter forces the high byte count to zero
// R4 - status bit 7 latches a rising edge of the selected input
// R5 - status bit 6 latches a low byte carry out
// R6 - status bit 5 latches a high byte carry out
// R7 - status bit 4 latches completion of a width or period measurement
// R8 - writing zero clears a flag, writing one leaves it
// R9 - mask bits 3 to 0 gate the four events onto the interrupt
// R10 - software keeps mask bits unchanged while the block is enabled
// R11 - timer register holds a 7-bit count in bits 6 to 0
// R12 - timer bit 7 selects one 8-bit or two 7-bit current converters
// R13 - low byte register reads lower count byte, zeroed when disabled
// R14 - interrupt is the OR of flags anded with their masks
// R15 - slew register keeps one bit in position 0, others read zero
module touch_sense_counter_status (
  input  wire       clk_sys,
  input  wire       srst,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire       count_enable,
  input  wire       count_run,
  input  wire       sense_input,
  input  wire       measurement_done,
  output reg        block_irq,
  output reg  [6:0] timer_count,
  output reg        dual_current_dac_select,
  output reg        slew_setting_bit
);
  wire [7:0] count_low_byte;
  wire [7:0] count_high_byte;
  wire       low_carry_pulse;
  wire       high_carry_pulse;
  reg        sense_input_q;
  reg  [3:0] flags_q;
  reg  [3:0] flags_d;
  reg  [3:0] masks_q;
  reg  [3:0] set_d;
  reg        flag_wr;
  reg  [7:0] rdata_d;

  // ==========================================================
  // counter
  sense_counter16 #(
    .WIDTH (8)
  ) u_counter (
    .clk_sys          (clk_sys),
    .srst             (srst),
    .count_enable     (count_enable),
    .count_run        (count_run),
    .count_low_byte   (count_low_byte),
    .count_high_byte  (count_high_byte),
    .low_carry_pulse  (low_carry_pulse),
    .high_carry_pulse (high_carry_pulse)
  );

  // ==========================================================
  // event flags, set wins over clear
  always @*
  begin
    set_d[3] = sense_input & ~sense_input_q; // R4
    set_d[2] = low_carry_pulse;              // R5
    set_d[1] = high_carry_pulse;             // R6
    set_d[0] = measurement_done;             // R7
    flag_wr  = reg_wr && (reg_addr == `ADDR_EVENT_FLAGS);
    flags_d  = flags_q;
    if (flag_wr)
    begin
      flags_d = flags_q & reg_wdata[`BIT_INPUT_EDGE_FLAG:`BIT_MEAS_DONE_FLAG]; // R8
    end
    flags_d = flags_d | set_d;
  end

  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      sense_input_q <= 1'b0;
      flags_q       <= 4'h0;
      masks_q       <= 4'h0;
      block_irq     <= 1'b0;
    end
    else
    begin
      sense_input_q <= sense_input;
      flags_q       <= flags_d;
      if (flag_wr)
      begin
        masks_q <= reg_wdata[3:0]; // R9
      end
      block_irq <= |(flags_q & masks_q); // R9 R14
    end
  end

  // ==========================================================
  // control registers
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      timer_count             <= `RST_TIMER_COUNT;
      dual_current_dac_select <= 1'b0;
      slew_setting_bit        <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `ADDR_TIMER_COUNT)
      begin
        timer_count             <= reg_wdata[6:0]; // R11
        dual_current_dac_select <= reg_wdata[7];   // R12
      end
      if (reg_addr == `ADDR_SLEW_CONTROL)
      begin
        slew_setting_bit <= reg_wdata[0]; // R15
      end
    end
  end

  // ==========================================================
  // read path
  always @*
  begin
    rdata_d = `RST_BYTE;
    if (reg_rd)
    begin
      case (reg_addr)
        `ADDR_COUNT_LOW_BYTE:  rdata_d = count_low_byte;  // R13
        `ADDR_COUNT_HIGH_BYTE: rdata_d = count_high_byte; // R1
        `ADDR_EVENT_FLAGS:     rdata_d = {flags_q, masks_q};
        `ADDR_TIMER_COUNT:     rdata_d = {dual_current_dac_select, timer_count};
        `ADDR_SLEW_CONTROL:    rdata_d = {7'h00, slew_setting_bit}; // R15
        default:               rdata_d = `RST_BYTE;
      endcase
    end
  end

  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      reg_rdata <= `RST_BYTE;
    end
    else
    begin
      reg_rdata <= rdata_d;
    end
  end
endmodule
`default_nettype wire

// ==== verif/touch_sense_counter_status_properties.sv ====
// port assertions for the touch sense counter register block
`timescale 1ns/1ps
`default_nettype none
module touch_sense_counter_status_properties (
  input wire logic       clk_sys,
  input wire logic       srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       count_enable,
  input wire logic       sense_input,
  input wire logic       measurement_done,
  input wire logic       block_irq,
  input wire logic [6:0] timer_count,
  input wire logic       dual_current_dac_select,
  input wire logic       slew_setting_bit
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  property p_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("rdata not idle");
  property p_off; !count_enable ##1 (reg_rd && reg_addr[7:1] == 7'h52) |=> reg_rdata == 8'h00;
  endproperty
  a_off: assert property (p_off) else $error("count not zero");
  property p_edge; $rose(sense_input) ##2 (reg_rd && reg_addr == 8'ha6) |=> reg_rdata[7];
  endproperty
  a_edge: assert property (p_edge) else $error("edge flag");
  property p_meas; measurement_done ##1 (reg_rd && reg_addr == 8'ha6) |=> reg_rdata[4];
  endproperty
  a_meas: assert property (p_meas) else $error("done flag");
  property p_irq; $past(reg_rd && reg_addr == 8'ha6) |-> block_irq == |(reg_rdata[7:4] &
    reg_rdata[3:0]); endproperty
  a_irq: assert property (p_irq) else $error("irq level");
  property p_tmr; reg_wr && reg_addr == 8'ha7 |=> {dual_current_dac_select, timer_count} ==
    $past(reg_wdata); endproperty
  a_tmr: assert property (p_tmr) else $error("timer write");
  property p_trd; reg_rd && reg_addr == 8'ha7 |=> reg_rdata == {dual_current_dac_select,
    timer_count}; endproperty
  a_trd: assert property (p_trd) else $error("timer read");
  property p_slew; reg_rd && reg_addr == 8'ha8 |=> reg_rdata == {7'h00, slew_setting_bit};
  endproperty
  a_slew: assert property (p_slew) else $error("slew read");
endmodule
bind touch_sense_counter_status touch_sense_counter_status_properties i_props (.*);
`default_nettype wire

// ==== verif/touch_sense_counter_status_tb.sv ====
// self-checking bench for the touch sense counter register block
`timescale 1ns/1ps
`default_nettype none
module touch_sense_counter_status_tb;
  logic       clk_sys, srst, reg_wr, reg_rd, count_enable, count_run, sense_input;
  logic       measurement_done, block_irq, dual_current_dac_select, slew_setting_bit;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  logic [6:0] timer_count;
  logic [3:0] fl, mk;
  int         err_total, num_checks, cyc;
  int unsigned rs = 34612;
  touch_sense_counter_status i_touch_sense_counter_status (.*);
  function automatic logic [7:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[7:0];
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk("rdata", e, reg_rdata);
    @(posedge clk_sys);
  endtask
  task automatic run(input int n);
    count_run <= 1'b1;
    repeat (n) @(posedge clk_sys);
    count_run <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      err_total++;
      end_of_test();
    end
  end
  // =========================================
  // main sequence
  initial
  begin
    {reg_wr, reg_rd, count_enable, count_run, sense_input, measurement_done} = 6'h00;
    {reg_addr, reg_wdata, fl, mk} = 24'h000000;
    srst = 1'b1;
    err_total = 0;
    num_checks = 0;
    cyc = 0;
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    for (int a = 8'ha3; a < 8'ha9; a++) rd(a[7:0], 8'h00);
    wr(8'ha3, 8'h5a);
    wr(8'ha5, 8'h5a);
    rd(8'ha3, 8'h00);
    rd(8'ha5, 8'h00);
    repeat (4)
    begin
      v = xs();
      wr(8'ha7, v);
      rd(8'ha7, v);
      wr(8'ha8, v);
      rd(8'ha8, {7'h00, v[0]});
    end
    mk = 4'hf;
    wr(8'ha6, 8'hff);
    count_enable <= 1'b1;
    run(300);
    fl[2] = 1'b1;
    rd(8'ha4, 8'h2c);
    rd(8'ha5, 8'h01);
    run(65240);
    fl[1] = 1'b1;
    rd(8'ha4, 8'h04);
    rd(8'ha6, {fl, mk});
    sense_input <= 1'b1;
    @(posedge clk_sys);
    sense_input <= 1'b0;
    measurement_done <= 1'b1;
    @(posedge clk_sys);
    measurement_done <= 1'b0;
    fl = 4'hf;
    rd(8'ha6, {fl, mk});
    count_enable <= 1'b0;
    @(posedge clk_sys);
    rd(8'ha4, 8'h00);
    rd(8'ha5, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      v = xs();
      chk("irq", {7'h00, |(fl & mk)}, {7'h00, block_irq});
      mk = v[3:0];
      wr(8'ha6, {~(4'h8 >> i), mk});
      fl = fl & ~(4'h8 >> i);
      rd(8'ha6, {fl, mk});
    end
    chk("irq", 8'h00, {7'h00, block_irq});
    end_of_test();
  end
endmodule
`default_nettype wire
